// ---- hw/llrm_function_unit.sv ----
// Look-up function unit: quad, five-input, combining, memory and ripple.
// Operands come from logic on the same clock; results are registered.
`timescale 1ns/1ps

module llrm_function_unit (
   input  wire logic                        clk_sys_in,
   input  wire logic                        rst_n_in,
   input  wire logic [llrm_pkg::ADDR_W-1:0] reg_addr_in,
   input  wire logic [llrm_pkg::DATA_W-1:0] reg_wdata_in,
   input  wire logic                        reg_wr_in,
   input  wire logic                        reg_rd_in,
   output logic      [llrm_pkg::DATA_W-1:0] reg_rdata_out,
   input  wire llrm_pkg::llrm_operands_s    operands_in,
   output llrm_pkg::llrm_results_s          results_out,
   output logic      [3:0]                  register_data_out
);

   typedef struct packed {
      llrm_pkg::llrm_ctrl_s            ctrl;
      logic [llrm_pkg::TABLE_W-1:0]    table_bits;
      llrm_pkg::llrm_results_s         res;
      logic [llrm_pkg::DATA_W-1:0]     rdata;
   } llrm_state_s;

   llrm_state_s state_r;
   llrm_state_s state_nxt;

   llrm_pkg::llrm_ctrl_s ctrl;
   logic [llrm_pkg::HALF_W-1:0]  upper_tab;
   logic [llrm_pkg::HALF_W-1:0]  lower_tab;
   logic [4:0] a;
   logic [4:0] b;
   logic       side;
   logic [3:0] quad_res;
   logic       five_up;
   logic       five_lo;
   logic [1:0] mem_up;
   logic [1:0] mem_lo;
   logic       both_five;
   logic [3:0] logic_res;
   logic [3:0] rip_b;
   logic       rip_c0;
   logic       carry_sel;
   logic [4:0] carry;
   logic [3:0] rip_res;

   assign ctrl      = state_r.ctrl;
   assign upper_tab = state_r.table_bits[63:32];
   assign lower_tab = state_r.table_bits[31:0];
   assign a         = operands_in.a;
   assign b         = operands_in.b;
   assign side      = operands_in.fast_side;

   // half-table evaluation
   always_comb begin
      // quarters 0,1 lower half, 2,3 upper half
      quad_res[0] = lower_tab[{b[3:1], b[0]}];
      quad_res[1] = lower_tab[{1'b1, b[3:1], b[4]}];
      quad_res[2] = upper_tab[{1'b0, a[3:1], a[0]}];
      quad_res[3] = upper_tab[{1'b1, a[3:1], a[4]}];
      five_up = upper_tab[a];
      five_lo = lower_tab[b];
      // memory read: one bit from each quarter of the half
      mem_lo = {lower_tab[{1'b1, b[3:0]}], lower_tab[{1'b0, b[3:0]}]};
      mem_up = {upper_tab[{1'b1, a[3:0]}], upper_tab[{1'b0, a[3:0]}]};
      both_five = (ctrl.upper == llrm_pkg::HALF_FIVE) &&
                  (ctrl.lower == llrm_pkg::HALF_FIVE);
   end

   // each half picks its own mode
   always_comb begin
      logic_res = 4'h0;
      case (ctrl.lower)
         llrm_pkg::HALF_QUAD: logic_res[1:0] = quad_res[1:0];
         llrm_pkg::HALF_FIVE: logic_res[0]   = five_lo;
         llrm_pkg::HALF_MEM:  logic_res[1:0] = mem_lo;
         default:             logic_res[1:0] = 2'h0;
      endcase
      case (ctrl.upper)
         llrm_pkg::HALF_QUAD: logic_res[3:2] = quad_res[3:2];
         llrm_pkg::HALF_FIVE: logic_res[3]   = five_up;
         llrm_pkg::HALF_MEM:  logic_res[3:2] = mem_up;
         default:             logic_res[3:2] = 2'h0;
      endcase
      // combining gates only when both halves are five-input
      if (both_five && ctrl.comb == llrm_pkg::COMB_MUX) begin
         logic_res[1] = side ? five_up : five_lo;
         logic_res[2] = ~(five_up & five_lo & side);
      end else if (both_five && ctrl.comb == llrm_pkg::COMB_XOR) begin
         logic_res[1] = five_up ^ five_lo ^ side;
         logic_res[2] = ~(five_up & five_lo & side);
      end
   end

   // ripple datapath operand shaping
   always_comb begin
      case (ctrl.csel)
         llrm_pkg::CSEL_CHAIN: carry_sel = operands_in.carry_in;
         llrm_pkg::CSEL_BTOP:  carry_sel = b[4];
         llrm_pkg::CSEL_ONE:   carry_sel = 1'b1;
         default:              carry_sel = 1'b0;
      endcase
      rip_b  = b[3:0];
      rip_c0 = carry_sel;
      case (ctrl.sub)
         llrm_pkg::SUB_ADD:   rip_b = a[4] ? ~b[3:0] : b[3:0];
         llrm_pkg::SUB_COUNT: begin
            // up adds carry 1, down adds all ones
            rip_b  = a[4] ? 4'h0 : 4'hf;
            rip_c0 = a[4];
         end
         llrm_pkg::SUB_MULT:  rip_b = a[4] ? b[3:0] : 4'h0;
         default:             rip_c0 = 1'b0;
      endcase
   end

   // per-quarter propagate/generate carry chain
   always_comb begin
      logic p;
      p = 1'b0;
      carry[0] = rip_c0;
      rip_res = 4'h0;
      for (int q = 0; q < 4; q++) begin
         p = a[q] ^ rip_b[q];
         if (ctrl.sub == llrm_pkg::SUB_EQ) begin
            rip_res[q]   = p;
            carry[q+1]   = carry[q] | p;
         end else begin
            rip_res[q]   = p ^ carry[q];
            carry[q+1]   = p ? carry[q] : a[q];
         end
      end
   end

   // register port, table and result update
   always_comb begin
      state_nxt = state_r;
      if (ctrl.ripple) begin
         state_nxt.res.result     = rip_res;
         state_nxt.res.carry_out  = ctrl.route_chain & carry[4];
         state_nxt.res.unit_out_4 = ctrl.route_o4 & carry[4];
      end else begin
         state_nxt.res.result     = logic_res;
         state_nxt.res.carry_out  = 1'b0;
         state_nxt.res.unit_out_4 = 1'b0;
         // memory write: top input and side input as write-port enable
         if (ctrl.lower == llrm_pkg::HALF_MEM && b[4] && side) begin
            state_nxt.table_bits[{2'h0, b[3:0]}] = operands_in.wdata[0];
            state_nxt.table_bits[{2'h1, b[3:0]}] = operands_in.wdata[1];
         end
         if (ctrl.upper == llrm_pkg::HALF_MEM && a[4] && side) begin
            state_nxt.table_bits[{2'h2, a[3:0]}] = operands_in.wdata[2];
            state_nxt.table_bits[{2'h3, a[3:0]}] = operands_in.wdata[3];
         end
      end
      if (reg_wr_in) begin
         if (reg_addr_in == llrm_pkg::OFS_CTRL) begin
            state_nxt.ctrl = llrm_pkg::llrm_ctrl_s'(
               reg_wdata_in[llrm_pkg::CTRL_W-1:0]);
         end else if (reg_addr_in == llrm_pkg::OFS_TAB_LO) begin
            state_nxt.table_bits[31:0] = reg_wdata_in;
         end else if (reg_addr_in == llrm_pkg::OFS_TAB_HI) begin
            state_nxt.table_bits[63:32] = reg_wdata_in;
         end
      end
      state_nxt.rdata = 32'h0;
      if (reg_rd_in) begin
         if (reg_addr_in == llrm_pkg::OFS_CTRL) begin
            state_nxt.rdata = {19'h0, state_r.ctrl};
         end else if (reg_addr_in == llrm_pkg::OFS_TAB_LO) begin
            state_nxt.rdata = state_r.table_bits[31:0];
         end else if (reg_addr_in == llrm_pkg::OFS_TAB_HI) begin
            state_nxt.rdata = state_r.table_bits[63:32];
         end else if (reg_addr_in == llrm_pkg::OFS_STATUS) begin
            state_nxt.rdata = {26'h0, state_r.res};
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r.ctrl       <= llrm_pkg::llrm_ctrl_s'(llrm_pkg::CTRL_RST);
         state_r.table_bits <= llrm_pkg::TABLE_RST;
         state_r.res        <= 6'h00;
         state_r.rdata      <= 32'h0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign reg_rdata_out     = state_r.rdata;
   assign results_out       = state_r.res;
   assign register_data_out = state_r.res.result;

   // checks
   logic rip_add;
   logic rip_cnt;
   logic rip_mul;
   logic rip_eq;
   logic comb_ok;
   assign rip_add = ctrl.ripple && ctrl.sub == llrm_pkg::SUB_ADD;
   assign rip_cnt = ctrl.ripple && ctrl.sub == llrm_pkg::SUB_COUNT;
   assign rip_mul = ctrl.ripple && ctrl.sub == llrm_pkg::SUB_MULT;
   assign rip_eq  = ctrl.ripple && ctrl.sub == llrm_pkg::SUB_EQ;
   assign comb_ok = !ctrl.ripple && both_five && !reg_wr_in;

   sequence mem_write_lo;
      !ctrl.ripple && ctrl.lower == llrm_pkg::HALF_MEM && b[4] && side
         && !reg_wr_in;
   endsequence

   sequence mem_read_same;
      ##1 !reg_wr_in && !ctrl.ripple && ctrl.lower == llrm_pkg::HALF_MEM
         && b[3:0] == $past(b[3:0]) ##1 1'b1;
   endsequence

   chk_mem_roundtrip: assert property (
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      mem_write_lo ##0 mem_read_same |->
         results_out.result[1:0] == $past(operands_in.wdata[1:0], 2))
      else $error("memory half did not return written data");

   chk_add_sum: assert property (
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      rip_add && !a[4] && ctrl.route_chain |=>
         {results_out.carry_out, results_out.result} ==
         {1'b0, $past(a[3:0])} + {1'b0, $past(b[3:0])} +
         {4'h0, $past(carry_sel)})
      else $error("ripple add result wrong");

   chk_count_step: assert property (
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      rip_cnt |=> results_out.result ==
         ($past(a[4]) ? $past(a[3:0]) + 4'h1 : $past(a[3:0]) - 4'h1))
      else $error("counter step wrong");

   chk_mult_acc: assert property (
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      rip_mul |=> results_out.result == 4'($past(a[3:0]) +
         ($past(a[4]) ? $past(b[3:0]) : 4'h0) + $past(carry_sel)))
      else $error("multiply accumulate wrong");

   chk_eq_carry: assert property (
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      rip_eq && ctrl.route_o4 |=>
         results_out.unit_out_4 == ($past(a[3:0]) != $past(b[3:0])))
      else $error("equality carry wrong");

   chk_mux_out: assert property (
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      comb_ok && ctrl.comb == llrm_pkg::COMB_MUX |=>
         results_out.result[1] == ($past(side) ? results_out.result[3]
                                               : results_out.result[0]))
      else $error("mux combine wrong");

   chk_xor_out: assert property (
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      comb_ok && ctrl.comb == llrm_pkg::COMB_XOR |=>
         results_out.result[1] == (results_out.result[3] ^
            results_out.result[0] ^ $past(side)))
      else $error("xor combine wrong");

   chk_nand_out: assert property (
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      comb_ok && (ctrl.comb == llrm_pkg::COMB_MUX ||
                  ctrl.comb == llrm_pkg::COMB_XOR) |=>
         results_out.result[2] == !(results_out.result[3] &&
            results_out.result[0] && $past(side)))
      else $error("nand gate wrong");

   chk_route_off: assert property (
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      !ctrl.ripple || (!ctrl.route_chain && !ctrl.route_o4) |=>
         !results_out.carry_out && !results_out.unit_out_4)
      else $error("carry routed while disabled");

endmodule

// ---- include/llrm_pkg.sv ----
// Constants, types and register map of the configurable look-up function unit.
// Assumes a single 25 MHz clock and a simple strobe register port.
//
// Behaviour
// - ripple operation takes the whole table; no logic or memory then
// - outside ripple each half table is configured on its own
// - async memory: each half is a 16x2 memory, set per half
// - quad: two quarters of a half share operand bits 1 to 3
// - quad results go to register data outputs and unit outputs
// - five-input: upper half of operand a on result_3, lower of b on result_0
// - one half five-input, other quad, allowed in either arrangement
// - mux combine: result_1 is upper result if side input 1, else lower
// - xor combine: result_1 is upper xor lower xor side input
// - both combines: result_2 is nand of upper, lower and side input
// - mux and xor combine are mutually exclusive
// - combine only with both halves five-input; five results stay visible
// - six-input: same five signals on both buses, sixth on side input
// - ripple carry chains quarters; quarter 0 carry from selectable source
// - nibbles on low operand bits; last carry to chain out, output 4
// - adder/subtractor: propagate or generate per bit; a top bit selects
// - counter: operand a nibble plus or minus one by a top bit
// - multiplier: partial product plus multiplicand if a top bit is 1
// - equality: carry in forced 0; carry out 0 if equal, 1 if not
// - ordered compares use subtraction, not the equality submode
// - upper half is quarters 2,3; lower 0,1; quarter n drives result n

package llrm_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_TAB_LO = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_TAB_HI = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;

   localparam int CTRL_W  = 13;
   localparam int TABLE_W = 64;
   localparam int HALF_W  = 32;
   localparam int QUART_W = 16;

   localparam logic [CTRL_W-1:0]  CTRL_RST  = 13'h0000;
   localparam logic [TABLE_W-1:0] TABLE_RST = 64'h0;

   typedef enum logic [1:0] {HALF_QUAD, HALF_FIVE, HALF_MEM, HALF_RSVD}
      llrm_half_e;
   typedef enum logic [1:0] {COMB_NONE, COMB_MUX, COMB_XOR, COMB_RSVD}
      llrm_comb_e;
   typedef enum logic [1:0] {SUB_ADD, SUB_COUNT, SUB_MULT, SUB_EQ}
      llrm_sub_e;
   typedef enum logic [1:0] {CSEL_CHAIN, CSEL_BTOP, CSEL_ONE, CSEL_ZERO}
      llrm_csel_e;

   // control register, bit 0 first from the bottom
   typedef struct packed {
      logic       route_o4;
      logic       route_chain;
      llrm_csel_e csel;
      llrm_sub_e  sub;
      llrm_comb_e comb;
      llrm_half_e lower;
      llrm_half_e upper;
      logic       ripple;
   } llrm_ctrl_s;

   typedef struct packed {
      logic [4:0] a;
      logic [4:0] b;
      logic       fast_side;
      logic       carry_in;
      logic [3:0] wdata;
   } llrm_operands_s;

   typedef struct packed {
      logic       carry_out;
      logic       unit_out_4;
      logic [3:0] result;
   } llrm_results_s;

endpackage

// ---- sim/llrm_fabric_model.sv ----
// Routing fabric model that feeds the operand buses of the function unit.
// Assumes the bench supplies raw operands and an optional six-input request.
`timescale 1ns/1ps

module llrm_fabric_model (
   input  wire logic                     six_en_in,
   input  wire logic [5:0]               six_sig_in,
   input  wire llrm_pkg::llrm_operands_s raw_in,
   output llrm_pkg::llrm_operands_s      operands_out
);
   // six-input: five signals on both buses, sixth on the side input
   always_comb begin
      operands_out = raw_in;
      if (six_en_in) begin
         operands_out.a         = six_sig_in[4:0];
         operands_out.b         = six_sig_in[4:0];
         operands_out.fast_side = six_sig_in[5];
      end
   end
endmodule

// ---- sim/llrm_function_unit_tb.sv ----
// Self-checking bench for the look-up function unit.
// Assumes the fabric model and the unit share one 25 MHz clock.
`timescale 1ns/1ps

module llrm_function_unit_tb;
   typedef struct packed {logic rd; logic [31:0] v; int due;} llrm_note_s;
   logic                     clk_sys_in;
   logic                     rst_n_in;
   logic                     wr;
   logic                     rd;
   logic                     six_en;
   logic [3:0]               addr;
   logic [31:0]              wdata;
   logic [31:0]              rdata;
   logic [3:0]               regd;
   logic [5:0]               six_sig;
   logic [15:0]              mv;
   logic [5:0]               last_exp;
   logic [31:0]              tlo;
   logic [31:0]              thi;
   llrm_pkg::llrm_operands_s raw;
   llrm_pkg::llrm_operands_s ops;
   llrm_pkg::llrm_results_s  res;
   llrm_pkg::llrm_ctrl_s     cfg;
   llrm_note_s               q[$];
   int                       ncnt;
   int                       error_cnt;
   int                       compares;
   int                       seed;
   int                       i;

   llrm_fabric_model u_llrm_fabric_model (.six_en_in(six_en),
      .six_sig_in(six_sig), .raw_in(raw), .operands_out(ops));
   llrm_function_unit u_llrm_function_unit (.clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .operands_in(ops), .results_out(res), .register_data_out(regd));

   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end

   function automatic logic [5:0] mdl(input llrm_pkg::llrm_operands_s o);
      logic [4:0] s;
      logic [3:0] bb;
      logic [5:0] r;
      logic       c;
      logic       f0;
      logic       f3;
      r  = 6'h0;
      f0 = tlo[o.b];
      f3 = thi[o.a];
      c  = cfg.csel[1] ? ~cfg.csel[0] : (cfg.csel[0] ? o.b[4] : o.carry_in);
      bb = o.a[4] ? ~o.b[3:0] : o.b[3:0];
      if (cfg.ripple) begin
         case (cfg.sub)
            llrm_pkg::SUB_ADD: s = o.a[3:0] + bb + 5'(c);
            llrm_pkg::SUB_COUNT: s = o.a[3:0] + (o.a[4] ? 5'h01 : 5'h0f);
            llrm_pkg::SUB_MULT: s = o.a[3:0] + (o.b[3:0] & {4{o.a[4]}}) + 5'(c);
            default: s = {|(o.a[3:0] ^ o.b[3:0]), o.a[3:0] ^ o.b[3:0]};
         endcase
         r = {s[4] & cfg.route_chain, s[4] & cfg.route_o4, s[3:0]};
      end else begin
         if (cfg.lower == llrm_pkg::HALF_QUAD) begin
            r[1:0] = {tlo[{1'b1, o.b[3:1], o.b[4]}], tlo[{1'b0, o.b[3:0]}]};
         end
         if (cfg.upper == llrm_pkg::HALF_QUAD) begin
            r[3:2] = {thi[{1'b1, o.a[3:1], o.a[4]}], thi[{1'b0, o.a[3:0]}]};
         end
         if (cfg.lower == llrm_pkg::HALF_MEM) begin
            r[1:0] = {tlo[{1'b1, o.b[3:0]}], tlo[{1'b0, o.b[3:0]}]};
         end
         if (cfg.upper == llrm_pkg::HALF_MEM) begin
            r[3:2] = {thi[{1'b1, o.a[3:0]}], thi[{1'b0, o.a[3:0]}]};
         end
         if (cfg.lower == llrm_pkg::HALF_FIVE) r[0] = f0;
         if (cfg.upper == llrm_pkg::HALF_FIVE) r[3] = f3;
         if (r[2:1] == 2'h0 && cfg.upper == cfg.lower
               && cfg.lower == llrm_pkg::HALF_FIVE && cfg.comb != 2'h0
               && cfg.comb != llrm_pkg::COMB_RSVD) begin
            r[1] = (cfg.comb == llrm_pkg::COMB_MUX) ? (o.fast_side ? f3 : f0)
                   : f3 ^ f0 ^ o.fast_side;
            r[2] = ~(f3 & f0 & o.fast_side);
         end
      end
      return r;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   always @(negedge clk_sys_in) begin
      ncnt++;
      while (q.size() > 0 && q[0].due == ncnt) begin
         if (q[0].rd) begin
            chk(rdata, q[0].v);
         end else begin
            chk({26'h0, res}, q[0].v);
            chk({28'h0, regd}, {28'h0, q[0].v[3:0]});
         end
         void'(q.pop_front());
      end
   end

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_sys_in);
      wr <= 1'b0;
      if (a == 4'h0) cfg = llrm_pkg::llrm_ctrl_s'(d[12:0]);
      if (a == 4'h4) tlo = d;
      if (a == 4'h8) thi = d;
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys_in);
      addr <= a;
      rd   <= 1'b1;
      q.push_back('{1'b1, e, ncnt + 2});
      @(posedge clk_sys_in);
      rd <= 1'b0;
   endtask

   task automatic op(input logic [15:0] v, input logic six);
      llrm_pkg::llrm_operands_s o;
      @(posedge clk_sys_in);
      raw     <= v;
      six_en  <= six;
      six_sig <= {v[5], v[15:11]};
      o = six ? {v[15:11], v[15:11], v[5:0]} : v;
      last_exp = mdl(o);
      q.push_back('{1'b0, {26'h0, last_exp}, ncnt + 2});
      // memory halves take the write at the edge that samples o
      if (!cfg.ripple && o.fast_side) begin
         if (cfg.lower == llrm_pkg::HALF_MEM && o.b[4]) begin
            tlo[{1'b0, o.b[3:0]}] = o.wdata[0];
            tlo[{1'b1, o.b[3:0]}] = o.wdata[1];
         end
         if (cfg.upper == llrm_pkg::HALF_MEM && o.a[4]) begin
            thi[{1'b0, o.a[3:0]}] = o.wdata[2];
            thi[{1'b1, o.a[3:0]}] = o.wdata[3];
         end
      end
   endtask

   task automatic conclude;
      $display("error_cnt=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      {rst_n_in, wr, rd, six_en, addr, wdata, raw, six_sig} = '0;
      {cfg, tlo, thi, ncnt, error_cnt, compares} = '0;
      seed = 33;
      repeat (6) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      rd_reg(4'h0, 32'h0);
      rd_reg(4'h4, 32'h0);
      rd_reg(4'h8, 32'h0);
      rd_reg(4'h2, 32'h0);
      op(16'hffff, 1'b0);
      wr_reg(4'h4, $random(seed));
      wr_reg(4'h8, $random(seed));
      wr_reg(4'hc, 32'hffffffff);
      wr_reg(4'h0, 32'hffffe000);
      rd_reg(4'h4, tlo);
      rd_reg(4'h8, thi);
      rd_reg(4'h0, 32'h0);
      // every quad/five-input half arrangement under no combine, mux combine and xor combine
      for (i = 0; i < 12; i++) begin
         wr_reg(4'h0, {25'h0, 2'(i / 4), 1'b0, i[1], 1'b0, i[0], 1'b0});
         repeat (8) op(16'($random(seed)), 1'b0);
      end
      // side input low first, so no stale write lands in memory mode
      op(16'h0000, 1'b0);
      // memory halves alone and beside a five-input half
      for (i = 0; i < 36; i++) begin
         if (i == 0) wr_reg(4'h0, 32'h14);
         if (i == 12) wr_reg(4'h0, 32'h12);
         if (i == 24) wr_reg(4'h0, 32'h0c);
         mv = 16'($random(seed)) | 16'h8420;
         op(mv, 1'b0);
         op(mv & 16'hffdf, 1'b0);
      end
      rd_reg(4'h4, tlo);
      rd_reg(4'h8, thi);
      wr_reg(4'h0, 32'h2a);
      repeat (16) op(16'($random(seed)), 1'b1);
      // every submode, carry source and carry route
      for (i = 0; i < 64; i++) begin
         wr_reg(4'h0, {19'h0, i[5:4], i[3:2], i[1:0], 6'h0, 1'b1});
         repeat (4) op(16'($random(seed)), 1'b0);
      end
      wr_reg(4'h0, 32'h1881);
      op({5'h1f, 11'h0}, 1'b0);
      op({5'h00, 11'h0}, 1'b0);
      wr_reg(4'h0, 32'h1981);
      op({5'h05, 5'h05, 6'h3f}, 1'b0);
      rd_reg(4'hc, {26'h0, last_exp});
      for (i = 0; i < 50 && q.size() > 0; i++) @(posedge clk_sys_in);
      if (q.size() > 0) error_cnt++;
      conclude();
   end
endmodule
